/* File: verilog/pmsc_pkg.sv */
// package: register map, field positions, reset values and carrier types for power control
package pmsc_pkg;
	// register indices on the plain register port (bytes, 8-bit data)
	localparam logic [1:0] ADDR_UV = 2'h0; // undervoltage control and status
	localparam logic [1:0] ADDR_REG = 2'h1; // regulator and stop control and status
	localparam logic [1:0] ADDR_TRIP = 2'h2; // trip-point select
	// undervoltage register fields
	localparam int UV_FLAG = 7;
	localparam int UV_ACK = 6;
	localparam int UV_IRQ_EN = 5;
	localparam int UV_RST_EN = 4;
	localparam int UV_STOP_EN = 3;
	localparam int UV_DET_EN = 2;
	localparam int UV_BUF_EN = 0;
	// regulator register fields
	localparam int RG_STBY_EN = 7;
	localparam int RG_STBY_ST = 6;
	localparam int RG_EXIT_IRQ = 5;
	localparam int RG_DS_FLAG = 3;
	localparam int RG_DS_ACK = 2;
	localparam int RG_PPD_ALLOW = 1;
	localparam int RG_MODE_SEL = 0;
	// trip register field
	localparam int TR_SEL = 5;
	// reset values
	localparam logic [7:0] UV_RESET = 8'h1c;
	localparam logic [7:0] RG_RESET = 8'h00;
	localparam logic [7:0] TR_RESET = 8'h00;

	// register bus request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pmsc_req_s;

	// analog and system status inputs
	typedef struct packed {
		logic uv_event;
		logic stop_mode;
		logic standby_active;
		logic irq_event;
		logic deep_stop_wake;
	} pmsc_stat_s;

	// control outputs
	typedef struct packed {
		logic uv_irq;
		logic uv_reset;
		logic uv_detect_on;
		logic ref_buf_on;
		logic trip_high;
		logic standby_allow;
		logic deep_stop_sel;
	} pmsc_ctl_s;
endpackage

/* File: verilog/pmsc_ctrl.sv */
// power management control and status registers
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
module pmsc_ctrl (
	input wire logic ref_clk, // 250 MHz clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire pmsc_pkg::pmsc_req_s req, // register port request
	output logic [7:0] rdata, // read data, cycle after read
	input wire pmsc_pkg::pmsc_stat_s stat_in, // asynchronous status inputs
	output pmsc_pkg::pmsc_ctl_s ctl // control outputs
);

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	pmsc_pkg::pmsc_stat_s sync1;
	pmsc_pkg::pmsc_stat_s sync2;
	pmsc_pkg::pmsc_stat_s next_sync1;
	pmsc_pkg::pmsc_stat_s next_sync2;

	// two flops per asynchronous status line
	always_comb begin
		next_sync1 = stat_in;
		next_sync2 = sync1;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register state, undervoltage group
	logic uv_flag; // undervoltage detect flag
	logic uv_irq_en; // interrupt enable
	logic uv_rst_en; // reset enable, write-once
	logic uv_stop_en; // keep detection running in stop
	logic uv_det_en; // detector enable, write-once
	logic uv_buf_en; // reference buffer enable
	logic rst_en_done; // reset enable already written
	logic det_en_done; // detector enable already written
	logic next_uv_flag;
	logic next_uv_irq_en;
	logic next_uv_rst_en;
	logic next_uv_stop_en;
	logic next_uv_det_en;
	logic next_uv_buf_en;
	logic next_rst_en_done;
	logic next_det_en_done;

	// register state, regulator group
	logic stby_en; // regulator standby enable
	logic exit_irq; // leave standby on interrupt
	logic ds_flag; // deep stop recovered flag
	logic ppd_allow; // partial powerdown allow, write-once
	logic ppd_allow_done; // allow bit already written
	logic mode_sel; // powerdown mode select
	logic next_stby_en;
	logic next_exit_irq;
	logic next_ds_flag;
	logic next_ppd_allow;
	logic next_ppd_allow_done;
	logic next_mode_sel;

	// register state, trip group
	logic trip_sel; // high trip point when set
	logic next_trip_sel;

	// read path
	logic [7:0] rd_q; // registered read data
	logic [7:0] next_rd_q;
	logic [7:0] uv_view; // undervoltage register as software sees it
	logic [7:0] rg_view; // regulator register as software sees it
	logic [7:0] tr_view; // trip register as software sees it

	// decoded strobes and events
	logic wr_uv; // write to undervoltage register
	logic wr_rg; // write to regulator register
	logic wr_tr; // write to trip register
	logic uv_ack; // undervoltage acknowledge written
	logic ds_ack; // deep stop acknowledge written
	logic uv_set; // qualified undervoltage event
	logic ds_set; // deep stop recovery seen
	logic irq_wake; // interrupt while wake bit set
	logic mode_req; // write asks for mode select
	logic mode_ok; // mode select request may be taken
	logic uv_live; // detector running now

	////////////////////////////////////////////////////////////////////////////
	// decode

	// write decode
	assign wr_uv = req.wr && (req.addr == pmsc_pkg::ADDR_UV);
	assign wr_rg = req.wr && (req.addr == pmsc_pkg::ADDR_REG);
	assign wr_tr = req.wr && (req.addr == pmsc_pkg::ADDR_TRIP);

	// acknowledge strobes, one cycle each
	assign uv_ack = wr_uv && req.wdata[pmsc_pkg::UV_ACK];
	assign ds_ack = wr_rg && req.wdata[pmsc_pkg::RG_DS_ACK];

	// detection active: enabled, and in stop only with stop enable
	assign uv_live = uv_det_en && (!sync2.stop_mode || uv_stop_en);

	// hardware events, already synchronised
	assign uv_set = uv_live && sync2.uv_event;
	assign ds_set = sync2.deep_stop_wake;
	assign irq_wake = exit_irq && sync2.irq_event;

	// mode select request, refused while standby enable is set
	assign mode_req = wr_rg && req.wdata[pmsc_pkg::RG_MODE_SEL];
	assign mode_ok = mode_req && !stby_en;

	////////////////////////////////////////////////////////////////////////////
	// undervoltage group

	// next values: flag, plain bits and write-once bits
	always_comb begin
		next_uv_flag = uv_flag;
		next_uv_irq_en = uv_irq_en;
		next_uv_rst_en = uv_rst_en;
		next_uv_stop_en = uv_stop_en;
		next_uv_det_en = uv_det_en;
		next_uv_buf_en = uv_buf_en;
		next_rst_en_done = rst_en_done;
		next_det_en_done = det_en_done;
		// acknowledge clears the flag
		if (uv_ack) begin
			next_uv_flag = 1'b0;
		end
		// event set wins over acknowledge
		if (uv_set) begin
			next_uv_flag = 1'b1;
		end
		// plain read/write bits
		if (wr_uv) begin
			next_uv_irq_en = req.wdata[pmsc_pkg::UV_IRQ_EN];
			next_uv_stop_en = req.wdata[pmsc_pkg::UV_STOP_EN];
			next_uv_buf_en = req.wdata[pmsc_pkg::UV_BUF_EN];
		end
		// reset enable takes the first write only
		if (wr_uv && !rst_en_done) begin
			next_uv_rst_en = req.wdata[pmsc_pkg::UV_RST_EN];
			next_rst_en_done = 1'b1;
		end
		// detector enable takes the first write only
		if (wr_uv && !det_en_done) begin
			next_uv_det_en = req.wdata[pmsc_pkg::UV_DET_EN];
			next_det_en_done = 1'b1;
		end
	end

	// undervoltage group registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			uv_flag <= pmsc_pkg::UV_RESET[pmsc_pkg::UV_FLAG];
			uv_irq_en <= pmsc_pkg::UV_RESET[pmsc_pkg::UV_IRQ_EN];
			uv_rst_en <= pmsc_pkg::UV_RESET[pmsc_pkg::UV_RST_EN];
			uv_stop_en <= pmsc_pkg::UV_RESET[pmsc_pkg::UV_STOP_EN];
			uv_det_en <= pmsc_pkg::UV_RESET[pmsc_pkg::UV_DET_EN];
			uv_buf_en <= pmsc_pkg::UV_RESET[pmsc_pkg::UV_BUF_EN];
			rst_en_done <= 1'b0;
			det_en_done <= 1'b0;
		end else begin
			uv_flag <= next_uv_flag;
			uv_irq_en <= next_uv_irq_en;
			uv_rst_en <= next_uv_rst_en;
			uv_stop_en <= next_uv_stop_en;
			uv_det_en <= next_uv_det_en;
			uv_buf_en <= next_uv_buf_en;
			rst_en_done <= next_rst_en_done;
			det_en_done <= next_det_en_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// regulator group

	// next values: standby, wake, deep stop flag, allow and mode
	always_comb begin
		next_stby_en = stby_en;
		next_exit_irq = exit_irq;
		next_ds_flag = ds_flag;
		next_ppd_allow = ppd_allow;
		next_ppd_allow_done = ppd_allow_done;
		next_mode_sel = mode_sel;
		// wake bit is plain read/write
		if (wr_rg) begin
			next_exit_irq = req.wdata[pmsc_pkg::RG_EXIT_IRQ];
		end
		// acknowledge clears the recovery flag
		if (ds_ack) begin
			next_ds_flag = 1'b0;
		end
		// recovery from deep stop wins over acknowledge
		if (ds_set) begin
			next_ds_flag = 1'b1;
		end
		// allow bit takes the first write only
		if (wr_rg && !ppd_allow_done) begin
			next_ppd_allow = req.wdata[pmsc_pkg::RG_PPD_ALLOW];
			next_ppd_allow_done = 1'b1;
		end
		// mode select taken only while standby enable is clear
		if (mode_ok) begin
			next_mode_sel = 1'b1;
			next_stby_en = 1'b0;
		end else if (wr_rg) begin
			// a refused mode bit leaves a plain standby write
			if (!mode_req) begin
				next_mode_sel = 1'b0;
			end
			next_stby_en = req.wdata[pmsc_pkg::RG_STBY_EN];
		end
		// standby enable can never sit beside mode select
		if (next_mode_sel) begin
			next_stby_en = 1'b0;
		end
		// interrupt with wake bit drops standby enable
		if (irq_wake) begin
			next_stby_en = 1'b0;
		end
	end

	// regulator group registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stby_en <= pmsc_pkg::RG_RESET[pmsc_pkg::RG_STBY_EN];
			exit_irq <= pmsc_pkg::RG_RESET[pmsc_pkg::RG_EXIT_IRQ];
			ds_flag <= pmsc_pkg::RG_RESET[pmsc_pkg::RG_DS_FLAG];
			ppd_allow <= pmsc_pkg::RG_RESET[pmsc_pkg::RG_PPD_ALLOW];
			ppd_allow_done <= 1'b0;
			mode_sel <= pmsc_pkg::RG_RESET[pmsc_pkg::RG_MODE_SEL];
		end else begin
			stby_en <= next_stby_en;
			exit_irq <= next_exit_irq;
			ds_flag <= next_ds_flag;
			ppd_allow <= next_ppd_allow;
			ppd_allow_done <= next_ppd_allow_done;
			mode_sel <= next_mode_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// trip group

	// next value: trip select is plain read/write
	always_comb begin
		next_trip_sel = trip_sel;
		if (wr_tr) begin
			next_trip_sel = req.wdata[pmsc_pkg::TR_SEL];
		end
	end

	// trip group register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			trip_sel <= pmsc_pkg::TR_RESET[pmsc_pkg::TR_SEL];
		end else begin
			trip_sel <= next_trip_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path

	// undervoltage view, acknowledge and reserved bits read 0
	always_comb begin
		uv_view = 8'h00;
		uv_view[pmsc_pkg::UV_FLAG] = uv_flag;
		uv_view[pmsc_pkg::UV_IRQ_EN] = uv_irq_en;
		uv_view[pmsc_pkg::UV_RST_EN] = uv_rst_en;
		uv_view[pmsc_pkg::UV_STOP_EN] = uv_stop_en;
		uv_view[pmsc_pkg::UV_DET_EN] = uv_det_en;
		uv_view[pmsc_pkg::UV_BUF_EN] = uv_buf_en;
		uv_view[pmsc_pkg::UV_ACK] = 1'b0;
	end

	// regulator view, acknowledge bit reads 0
	always_comb begin
		rg_view = 8'h00;
		rg_view[pmsc_pkg::RG_STBY_EN] = stby_en;
		rg_view[pmsc_pkg::RG_STBY_ST] = sync2.standby_active;
		rg_view[pmsc_pkg::RG_EXIT_IRQ] = exit_irq;
		rg_view[pmsc_pkg::RG_DS_FLAG] = ds_flag;
		rg_view[pmsc_pkg::RG_PPD_ALLOW] = ppd_allow;
		rg_view[pmsc_pkg::RG_MODE_SEL] = mode_sel;
		rg_view[pmsc_pkg::RG_DS_ACK] = 1'b0;
	end

	// trip view, only the select bit is implemented
	always_comb begin
		tr_view = 8'h00;
		tr_view[pmsc_pkg::TR_SEL] = trip_sel;
	end

	// read mux, data stands one cycle after the strobe
	always_comb begin
		next_rd_q = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				pmsc_pkg::ADDR_UV: next_rd_q = uv_view;
				pmsc_pkg::ADDR_REG: next_rd_q = rg_view;
				pmsc_pkg::ADDR_TRIP: next_rd_q = tr_view;
				default: next_rd_q = 8'h00;
			endcase
		end
	end

	// read data register, zero when no read was made
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_q <= 8'h00;
		end else begin
			rd_q <= next_rd_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign rdata = rd_q;
	assign ctl.uv_irq = uv_irq_en && uv_flag;
	assign ctl.uv_reset = uv_rst_en && uv_det_en && uv_flag;
	assign ctl.uv_detect_on = uv_live;
	assign ctl.ref_buf_on = uv_buf_en;
	assign ctl.trip_high = trip_sel;
	assign ctl.standby_allow = stby_en;
	assign ctl.deep_stop_sel = ppd_allow && mode_sel;

endmodule

/* File: testbench/pmsc_props.sv */
// checker: register view against control outputs
`timescale 1ns/10ps
module pmsc_props (
	input wire logic ref_clk, // clock
	input wire logic sys_rst, // sync reset
	input wire pmsc_pkg::pmsc_req_s req, // register request
	input wire logic [7:0] rdata, // read data
	input wire pmsc_pkg::pmsc_stat_s stat_in, // status inputs
	input wire pmsc_pkg::pmsc_ctl_s ctl // control outputs
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence rd_uv;
		req.rd && req.addr == pmsc_pkg::ADDR_UV;
	endsequence
	sequence rd_rg;
		req.rd && req.addr == pmsc_pkg::ADDR_REG;
	endsequence
	a_uv_irq_gate: assert property (rd_uv |=> (rdata[7] & rdata[5]) == $past(ctl.uv_irq))
		else $error("irq not flag and enable");
	a_uv_rst_gate: assert property (rd_uv |=> (rdata[7] & rdata[4] & rdata[2]) == $past(ctl.uv_reset))
		else $error("reset request wrong");
	a_uv_ack_zero: assert property (rd_uv |=> !rdata[6])
		else $error("uv ack reads one");
	a_ds_ack_zero: assert property (rd_rg |=> !rdata[2])
		else $error("deep stop ack reads one");
	a_buf_view: assert property (rd_uv |=> rdata[0] == $past(ctl.ref_buf_on))
		else $error("buffer enable mismatch");
	a_stby_view: assert property (rd_rg |=> rdata[7] == $past(ctl.standby_allow))
		else $error("standby enable mismatch");
	a_mode_excl: assert property (rd_rg |=> !(rdata[7] && rdata[0]))
		else $error("standby and mode both set");
	a_deep_sel: assert property (rd_rg |=> (rdata[1] & rdata[0]) == $past(ctl.deep_stop_sel))
		else $error("deep stop select wrong");
	a_both_set: assert property (req.wr && req.addr == pmsc_pkg::ADDR_REG && req.wdata[7]
		&& req.wdata[0] && !ctl.standby_allow |=> !ctl.standby_allow)
		else $error("standby set with mode");
endmodule

/* File: testbench/tb_top.sv */
// testbench: register port sequences with expected values
`timescale 1ns/10ps
module tb_top;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	pmsc_pkg::pmsc_req_s req = '0;
	pmsc_pkg::pmsc_stat_s stat_in = '0;
	logic [7:0] rdata;
	pmsc_pkg::pmsc_ctl_s ctl;
	int failures = 0;
	int compares = 0;
	// clock at 4 ns period
	always #2 ref_clk = ~ref_clk;
	pmsc_ctrl uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
		.stat_in(stat_in), .ctl(ctl));
	////////////////////////////////////////////////////////////////
	// compare, bus and status tasks
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req <= '0;
	endtask
	task rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req <= '0;
		#1 chk(rdata, exp);
	endtask
	task st(input logic [4:0] s);
		@(posedge ref_clk);
		stat_in <= s;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	task final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(2'h0, 8'h1c);
		rd(2'h1, 8'h00);
		rd(2'h2, 8'h00);
		rd(2'h3, 8'h00);
		wr(2'h0, 8'h35);
		rd(2'h0, 8'h35);
		chk({7'h0, ctl.ref_buf_on}, 8'h01);
		st(5'b01000);
		chk({7'h0, ctl.uv_detect_on}, 8'h00);
		st(5'b00000);
		wr(2'h0, 8'h28);
		rd(2'h0, 8'h3c);
		st(5'b01000);
		chk({7'h0, ctl.uv_detect_on}, 8'h01);
		st(5'b10000);
		rd(2'h0, 8'hbc);
		chk({6'h0, ctl.uv_irq, ctl.uv_reset}, 8'h03);
		st(5'b00000);
		wr(2'h0, 8'h68);
		rd(2'h0, 8'h3c);
		chk({6'h0, ctl.uv_irq, ctl.uv_reset}, 8'h00);
		wr(2'h1, 8'h02);
		rd(2'h1, 8'h02);
		wr(2'h1, 8'h81);
		rd(2'h1, 8'h03);
		chk({7'h0, ctl.deep_stop_sel}, 8'h01);
		wr(2'h1, 8'h02);
		wr(2'h1, 8'ha2);
		rd(2'h1, 8'ha2);
		wr(2'h1, 8'ha3);
		rd(2'h1, 8'ha2);
		st(5'b00101);
		rd(2'h1, 8'hea);
		st(5'b00010);
		rd(2'h1, 8'h2a);
		st(5'b00000);
		wr(2'h1, 8'h26);
		rd(2'h1, 8'h22);
		wr(2'h2, 8'h20);
		#1;
		chk({7'h0, ctl.trip_high}, 8'h01);
		wr(2'h3, 8'hff);
		rd(2'h3, 8'h00);
		// second reset: write-once bits open again
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		wr(2'h0, 8'h00);
		rd(2'h0, 8'h00);
		st(5'b10000);
		rd(2'h0, 8'h00);
		chk({7'h0, ctl.uv_detect_on}, 8'h00);
		wr(2'h0, 8'h14);
		rd(2'h0, 8'h00);
		chk({6'h0, ctl.uv_irq, ctl.uv_reset}, 8'h00);
		final_report;
	end
endmodule
bind pmsc_ctrl pmsc_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req),
	.rdata(rdata), .stat_in(stat_in), .ctl(ctl));
